/* rtl/lprtc_ctrl.sv */
/*
 * Control side of the low-power timekeeping block: counter mode select,
 * module enable, word store access, GPIO retention and interrupt unit.
 * Assumes one 100 MHz clock; wake and battery events arrive from pins or
 * analog logic and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module lprtc_ctrl
	import lprtc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Module enable and counter mode
	input wire logic enable_i,
	input wire logic mode_wr_i,
	input wire logic mode_calendar_24h_i,
	input wire logic mode_calendar_12h_ampm_i,
	output lprtc_mode_e mode_o,
	output logic mode_err_o,
	output logic calendar_ok_o,
	output logic active_o,
	// Word store
	input wire lprtc_mem_req_s mem_req_i,
	output logic [LPRTC_DATA_W-1:0] mem_rdata_o,
	output logic mem_rvalid_o,
	// Slow-domain register write
	input wire logic slow_wr_i,
	output logic slow_busy_o,
	// GPIO retention
	input wire logic ret_enable_i,
	input wire logic ret_release_i,
	input wire logic hibernate_i,
	input wire logic [LPRTC_GPIO_W-1:0] gpio_ctrl_out_i,
	input wire logic [LPRTC_GPIO_W-1:0] gpio_ctrl_oe_i,
	output logic [LPRTC_GPIO_W-1:0] gpio_pad_o,
	output logic [LPRTC_GPIO_W-1:0] gpio_pad_oe_o,
	output logic ret_status_o,
	output logic gpio_ctrl_rst_o,
	// Interrupt unit
	input wire lprtc_evt_s evt_i,
	input wire logic [LPRTC_IRQ_W-1:0] irq_en_set_i,
	input wire logic [LPRTC_IRQ_W-1:0] irq_en_clr_i,
	input wire logic [LPRTC_IRQ_W-1:0] irq_clear_i,
	output logic [LPRTC_IRQ_W-1:0] irq_raw_o,
	output logic [LPRTC_IRQ_W-1:0] irq_masked_o,
	output logic [LPRTC_IRQ_W-1:0] irq_en_o,
	output logic irq_o
);

	// ****************************************************************
	// Event input synchronisers
	// ****************************************************************
	logic [5:0] evt_s1; // First stage, read only by second
	logic [5:0] evt_s2; // Second stage
	logic [5:0] evt_s3; // Third stage
	logic [5:0] evt_last; // Last agreed level
	logic [5:0] evt_rise; // Agreed rising edge

	// Three-flop chain on asynchronous event lines
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			evt_s1 <= 6'h00;
			evt_s2 <= 6'h00;
			evt_s3 <= 6'h00;
		end
		else if (ce_i)
		begin
			evt_s1 <= evt_i;
			evt_s2 <= evt_s1;
			evt_s3 <= evt_s2;
		end
	end

	// Each bit's agreed level moves only when its stages two and three
	// match, so one noisy line cannot hold back the others
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			evt_last <= 6'h00;
		else if (ce_i)
			evt_last <= (evt_s3 & ~(evt_s2 ^ evt_s3)) | (evt_last & (evt_s2 ^ evt_s3));
	end

	always_comb
	begin
		evt_rise = (evt_s2 & evt_s3) & ~evt_last;
	end

	// ****************************************************************
	// Enable and counter mode
	// ****************************************************************
	logic en; // Module enabled

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			en <= 1'b0;
		else if (ce_i)
			en <= enable_i;
	end

	// Mode write: both calendar bits at once is refused
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mode_o <= LPRTC_MODE_SECONDS;
			mode_err_o <= 1'b0;
		end
		else if (ce_i && en && mode_wr_i)
		begin
			mode_err_o <= mode_calendar_24h_i & mode_calendar_12h_ampm_i;
			if (mode_calendar_24h_i && mode_calendar_12h_ampm_i)
				mode_o <= mode_o;
			else if (mode_calendar_24h_i)
				mode_o <= LPRTC_MODE_CAL24;
			else if (mode_calendar_12h_ampm_i)
				mode_o <= LPRTC_MODE_CAL12;
			else
				mode_o <= LPRTC_MODE_SECONDS;
		end
	end

	// Calendar access permitted only in a calendar mode
	always_comb
	begin
		calendar_ok_o = en && (mode_o != LPRTC_MODE_SECONDS);
		active_o = en;
	end

	// ****************************************************************
	// Word store
	// ****************************************************************
	logic mem_wr; // Gated write
	logic mem_rd; // Gated read

	always_comb
	begin
		mem_wr = en && mem_req_i.wr;
		mem_rd = en && mem_req_i.rd && !mem_req_i.wr;
	end

	lprtc_store u_store
	(
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.wr_i(mem_wr),
		.rd_i(mem_rd),
		.addr_i(mem_req_i.addr),
		.wdata_i(mem_req_i.wdata),
		.rdata_o(mem_rdata_o)
	);

	// Read data valid one cycle after the request
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mem_rvalid_o <= 1'b0;
		else if (ce_i)
			mem_rvalid_o <= mem_rd;
	end

	// ****************************************************************
	// Slow-domain write tracking
	// ****************************************************************
	logic [3:0] wr_cnt; // Cycles left for the write to land
	logic wr_done; // Write finished this cycle

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			wr_cnt <= 4'h0;
		else if (ce_i)
		begin
			if (!en)
				wr_cnt <= 4'h0;
			else if (slow_wr_i && wr_cnt == 4'h0)
				wr_cnt <= LPRTC_WR_CYCLES;
			else if (wr_cnt != 4'h0)
				wr_cnt <= wr_cnt - 4'h1;
		end
	end

	always_comb
	begin
		slow_busy_o = (wr_cnt != 4'h0);
		wr_done = en && (wr_cnt == 4'h1);
	end

	// ****************************************************************
	// GPIO retention
	// ****************************************************************
	logic ret_en; // Retention armed
	logic holding; // Latches own the pads
	logic [LPRTC_GPIO_W-1:0] hold_out; // Latched levels
	logic [LPRTC_GPIO_W-1:0] hold_oe; // Latched enables

	// Retention setting; release wins over enable
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			ret_en <= 1'b0;
		else if (ce_i)
		begin
			if (!en || ret_release_i)
				ret_en <= 1'b0;
			else if (ret_enable_i)
				ret_en <= 1'b1;
		end
	end

	// Capture pin state on hibernation entry, hold until release
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			holding <= 1'b0;
			hold_out <= LPRTC_GPIO_RST;
			hold_oe <= LPRTC_GPIO_RST;
		end
		else if (ce_i)
		begin
			if (!ret_en)
				holding <= 1'b0;
			else if (hibernate_i && !holding)
			begin
				holding <= 1'b1;
				hold_out <= gpio_ctrl_out_i;
				hold_oe <= gpio_ctrl_oe_i;
			end
		end
	end

	// Pad mux: latches drive while holding, pads undriven in hibernation without retention, controller otherwise
	always_comb
	begin
		gpio_ctrl_rst_o = hibernate_i;
		if (holding)
		begin
			gpio_pad_o = hold_out;
			gpio_pad_oe_o = hold_oe;
		end
		else if (hibernate_i && !ret_en)
		begin
			// No retention armed: nothing drives the pads
			gpio_pad_o = LPRTC_GPIO_RST;
			gpio_pad_oe_o = LPRTC_GPIO_RST;
		end
		else
		begin
			// Also the capture cycle on entry, so the pads do not drop
			// for one cycle before the latches take over
			gpio_pad_o = gpio_ctrl_out_i;
			gpio_pad_oe_o = gpio_ctrl_oe_i;
		end
		ret_status_o = ret_en;
	end

	// ****************************************************************
	// Interrupt unit
	// ****************************************************************
	logic [LPRTC_IRQ_W-1:0] irq_set; // New events this cycle

	always_comb
	begin
		irq_set = 7'h00;
		irq_set[LPRTC_IRQ_WR_DONE] = wr_done;
		irq_set[LPRTC_IRQ_PIN_WAKE] = evt_rise[0];
		irq_set[LPRTC_IRQ_BATTERY_LOW] = evt_rise[1];
		irq_set[LPRTC_IRQ_MATCH0] = evt_rise[2];
		irq_set[LPRTC_IRQ_RESET_WAKE] = evt_rise[4];
		irq_set[LPRTC_IRQ_GPIO_WAKE] = evt_rise[3] | evt_rise[4];
		irq_set[LPRTC_IRQ_SUPPLY_FAIL] = evt_rise[5];
		if (!en)
			irq_set = 7'h00;
	end

	// Enable mask; set wins over disable in the same cycle
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			irq_en_o <= LPRTC_IRQ_RST;
		else if (ce_i && en)
			irq_en_o <= (irq_en_o & ~irq_en_clr_i) | irq_en_set_i;
	end

	// Pending flags; a new event wins over a clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			irq_raw_o <= LPRTC_IRQ_RST;
		else if (ce_i)
			irq_raw_o <= (irq_raw_o & ~irq_clear_i) | irq_set;
	end

	// Masked status and interrupt line
	always_comb
	begin
		irq_masked_o = irq_raw_o & irq_en_o;
		irq_o = en && (|irq_masked_o);
	end

endmodule
`default_nettype wire

/* rtl/lprtc_pkg.sv */
/*
 * Package for the low-power timekeeping retention controller: counter
 * modes, interrupt source positions, reset values and storage geometry.
 * Assumes a single system clock domain; control bits are plain ports except the store request and event structs.
 */
`default_nettype none
package lprtc_pkg;

	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int LPRTC_DATA_W = 32;
	localparam int LPRTC_WORDS = 16;
	localparam int LPRTC_ADDR_W = 4;
	localparam int LPRTC_IRQ_W = 7;
	localparam int LPRTC_GPIO_W = 8;

	// ****************************************************************
	// Interrupt source bit positions
	// ****************************************************************
	localparam int LPRTC_IRQ_WR_DONE = 0;
	localparam int LPRTC_IRQ_PIN_WAKE = 1;
	localparam int LPRTC_IRQ_BATTERY_LOW = 2;
	localparam int LPRTC_IRQ_MATCH0 = 3;
	localparam int LPRTC_IRQ_SUPPLY_FAIL = 4;
	localparam int LPRTC_IRQ_RESET_WAKE = 5;
	localparam int LPRTC_IRQ_GPIO_WAKE = 6;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [6:0] LPRTC_IRQ_RST = 7'h00;
	localparam logic [7:0] LPRTC_GPIO_RST = 8'h00;
	// Cycles a slow-domain write takes to land
	localparam logic [3:0] LPRTC_WR_CYCLES = 4'h4;

	// Counter modes
	typedef enum logic [1:0]
	{
		LPRTC_MODE_SECONDS,
		LPRTC_MODE_CAL24,
		LPRTC_MODE_CAL12
	} lprtc_mode_e;

	// Interrupt event inputs
	typedef struct packed
	{
		logic supply_fail;
		logic reset_wake;
		logic gpio_wake;
		logic match0;
		logic battery_low;
		logic pin_wake;
	} lprtc_evt_s;

	// Storage access request
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} lprtc_mem_req_s;

endpackage
`default_nettype wire

/* rtl/lprtc_store.sv */
/*
 * Battery-backed word store: sixteen 32-bit words with registered read.
 * Assumes it sits on the always-on supply; it has no reset so its contents
 * survive any reset of the main logic.
 */
`timescale 1ns/1ps
`default_nettype none
module lprtc_store
	import lprtc_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	input wire logic ce_i,
	// Access
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [LPRTC_ADDR_W-1:0] addr_i,
	input wire logic [LPRTC_DATA_W-1:0] wdata_i,
	output logic [LPRTC_DATA_W-1:0] rdata_o
);

	// Storage array, never reset
	logic [LPRTC_DATA_W-1:0] mem [LPRTC_WORDS];

	// Write port
	always_ff @(posedge sys_clk_i)
	begin
		if (ce_i && wr_i)
			mem[addr_i] <= wdata_i;
	end

	// Registered read port
	always_ff @(posedge sys_clk_i)
	begin
		if (ce_i && rd_i)
			rdata_o <= mem[addr_i];
	end

endmodule
`default_nettype wire

/* verif/lprtc_ctrl_bench.sv */
/*
 * Self-checking bench for the timekeeping retention controller.
 * Assumes the checker is bound in; inputs change at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lprtc_ctrl_bench;
	import lprtc_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_b_i, ce_i, enable_i, mode_wr_i, slow_wr_i, hibernate_i;
	logic mode_calendar_24h_i, mode_calendar_12h_ampm_i;
	logic ret_enable_i, ret_release_i;
	logic [7:0] gpio_ctrl_out_i, gpio_ctrl_oe_i, gpio_pad_o, gpio_pad_oe_o;
	lprtc_mem_req_s mem_req_i;
	lprtc_evt_s evt_i;
	logic [6:0] irq_en_set_i, irq_en_clr_i, irq_clear_i;
	logic [6:0] irq_raw_o, irq_masked_o, irq_en_o;
	lprtc_mode_e mode_o;
	logic mode_err_o, calendar_ok_o, active_o, mem_rvalid_o, slow_busy_o;
	logic ret_status_o, gpio_ctrl_rst_o, irq_o;
	logic [31:0] mem_rdata_o;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	// Flags expected per event input bit
	logic [6:0] evt_exp [6] = '{7'h02, 7'h04, 7'h08, 7'h40, 7'h60, 7'h10};

	lprtc_ctrl dut (.*);

	always #5 sys_clk_i = ~sys_clk_i;

	// Hang guard
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	function automatic logic [31:0] pat(input int i);
		return 32'h5A000000 + 32'(i) * 32'h00010101;
	endfunction

	task automatic mode_w(input logic a, input logic b);
		mode_wr_i = 1'b1;
		mode_calendar_24h_i = a;
		mode_calendar_12h_ampm_i = b;
		tick(1);
		mode_wr_i = 1'b0;
		tick(1);
	endtask

	// Store access; a read checks the answer in the following cycle
	task automatic mem(input logic w, input int a, input logic [31:0] d, input logic v);
		mem_req_i = '{wr: w, rd: !w, addr: 4'(a), wdata: d};
		tick(1);
		mem_req_i = '0;
		if (!w)
		begin
			chk("rvalid", mem_rvalid_o, v);
			if (v)
				chk("rdata", mem_rdata_o, d);
		end
		tick(1);
	endtask

	task automatic mask(input logic [6:0] s, input logic [6:0] c, input logic [6:0] k);
		irq_en_set_i = s;
		irq_en_clr_i = c;
		irq_clear_i = k;
		tick(1);
		{irq_en_set_i, irq_en_clr_i, irq_clear_i} = '0;
		tick(1);
	endtask

	task automatic ret(input logic e, input logic r);
		ret_enable_i = e;
		ret_release_i = r;
		tick(1);
		{ret_enable_i, ret_release_i} = '0;
		tick(1);
	endtask

	task automatic fire(input logic [5:0] b);
		evt_i = lprtc_evt_s'(b);
		tick(6);
		evt_i = '0;
	endtask

	initial
	begin
		{rst_b_i, enable_i, mode_wr_i, slow_wr_i, hibernate_i} = '0;
		{mode_calendar_24h_i, mode_calendar_12h_ampm_i} = '0;
		{ret_enable_i, ret_release_i, irq_en_set_i} = '0;
		{irq_en_clr_i, irq_clear_i, gpio_ctrl_out_i, gpio_ctrl_oe_i} = '0;
		mem_req_i = '0;
		evt_i = '0;
		ce_i = 1'b1;
		tick(5);
		rst_b_i = 1'b1;
		chk("mode", mode_o, LPRTC_MODE_SECONDS);
		chk("raw", irq_raw_o, LPRTC_IRQ_RST);
		mode_w(1'b1, 1'b0);
		chk("mode", mode_o, LPRTC_MODE_SECONDS);
		mem(1'b0, 0, 32'h0, 1'b0);
		enable_i = 1'b1;
		tick(1);
		mode_w(1'b1, 1'b0);
		chk("mode", mode_o, LPRTC_MODE_CAL24);
		chk("cal", calendar_ok_o, 1'b1);
		mode_w(1'b0, 1'b1);
		chk("mode", mode_o, LPRTC_MODE_CAL12);
		mode_w(1'b1, 1'b1);
		chk("mode", mode_o, LPRTC_MODE_CAL12);
		chk("moderr", mode_err_o, 1'b1);
		mode_w(1'b0, 1'b0);
		chk("cal", calendar_ok_o, 1'b0);
		chk("moderr", mode_err_o, 1'b0);
		// Clock enable low freezes every register
		ce_i = 1'b0;
		mode_w(1'b1, 1'b0);
		chk("mode", mode_o, LPRTC_MODE_SECONDS);
		ce_i = 1'b1;
		for (int i = 0; i < LPRTC_WORDS; i++)
			mem(1'b1, i, pat(i), 1'b0);
		// Pads held through hibernation and wake
		gpio_ctrl_out_i = 8'hA5;
		gpio_ctrl_oe_i = 8'hFF;
		ret(1'b1, 1'b0);
		chk("retst", ret_status_o, 1'b1);
		hibernate_i = 1'b1;
		tick(1);
		{gpio_ctrl_out_i, gpio_ctrl_oe_i} = '0;
		tick(1);
		chk("pad", gpio_pad_o, 8'hA5);
		chk("padoe", gpio_pad_oe_o, 8'hFF);
		chk("grst", gpio_ctrl_rst_o, 1'b1);
		hibernate_i = 1'b0;
		tick(1);
		gpio_ctrl_out_i = 8'h3C;
		gpio_ctrl_oe_i = 8'hFF;
		tick(1);
		chk("pad", gpio_pad_o, 8'hA5);
		ret(1'b0, 1'b1);
		chk("retst", ret_status_o, 1'b0);
		chk("pad", gpio_pad_o, 8'h3C);
		hibernate_i = 1'b1;
		tick(2);
		chk("padoe", gpio_pad_oe_o, 8'h00);
		hibernate_i = 1'b0;
		// Every event source, one at a time
		mask(7'h7F, 7'h00, 7'h00);
		chk("ien", irq_en_o, 7'h7F);
		for (int i = 0; i < 6; i++)
		begin
			fire(6'h01 << i);
			chk("raw", irq_raw_o, evt_exp[i]);
			chk("irq", irq_o, 1'b1);
			mask(7'h00, 7'h00, 7'h7F);
			chk("raw", irq_raw_o, 7'h00);
		end
		mask(7'h00, 7'h20, 7'h00);
		chk("ien", irq_en_o, 7'h5F);
		slow_wr_i = 1'b1;
		tick(1);
		slow_wr_i = 1'b0;
		chk("busy", slow_busy_o, 1'b1);
		tick(4);
		chk("busy", slow_busy_o, 1'b0);
		chk("raw", irq_raw_o, 7'h01);
		fire(6'h10);
		chk("masked", irq_masked_o, 7'h41);
		mask(7'h00, 7'h7F, 7'h00);
		chk("irq", irq_o, 1'b0);
		chk("raw", irq_raw_o, 7'h61);
		mask(7'h00, 7'h00, 7'h01);
		chk("raw", irq_raw_o, 7'h60);
		// Store survives a reset of the main logic
		rst_b_i = 1'b0;
		tick(2);
		rst_b_i = 1'b1;
		tick(1);
		chk("active", active_o, 1'b1);
		for (int i = 0; i < LPRTC_WORDS; i++)
			mem(1'b0, i, pat(i), 1'b1);
		// An overwrite is what a later read returns
		mem(1'b1, 3, 32'h0F0F0F0F, 1'b0);
		mem(1'b0, 3, 32'h0F0F0F0F, 1'b1);
		report_and_stop();
	end
endmodule
`default_nettype wire

/* verif/lprtc_ctrl_sva.sv */
/*
 * Checker for the timekeeping retention controller, seeing its ports only.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module lprtc_ctrl_chk
	import lprtc_pkg::*;
(
	// Clock, reset and mode
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic enable_i,
	input wire logic active_o,
	input wire logic mode_wr_i,
	input wire logic mode_calendar_24h_i,
	input wire logic mode_calendar_12h_ampm_i,
	input wire lprtc_mode_e mode_o,
	input wire logic calendar_ok_o,
	// Store and slow write
	input wire lprtc_mem_req_s mem_req_i,
	input wire logic mem_rvalid_o,
	input wire logic slow_wr_i,
	input wire logic slow_busy_o,
	// Retention
	input wire logic ret_enable_i,
	input wire logic ret_release_i,
	input wire logic hibernate_i,
	input wire logic [LPRTC_GPIO_W-1:0] gpio_pad_oe_o,
	input wire logic ret_status_o,
	input wire logic gpio_ctrl_rst_o,
	// Interrupts
	input wire logic [LPRTC_IRQ_W-1:0] irq_en_clr_i,
	input wire logic [LPRTC_IRQ_W-1:0] irq_en_set_i,
	input wire logic [LPRTC_IRQ_W-1:0] irq_raw_o,
	input wire logic [LPRTC_IRQ_W-1:0] irq_masked_o,
	input wire logic [LPRTC_IRQ_W-1:0] irq_en_o,
	input wire logic irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Accepted slow-domain write and its busy run
	sequence s_slow_go;
		ce_i && active_o && slow_wr_i && !slow_busy_o;
	endsequence
	sequence s_slow_run;
		slow_busy_o [*4] ##1 (!slow_busy_o && irq_raw_o[0]);
	endsequence
	a_mode_legal: assert property (mode_o != 2'h3)
		else $error("mode out of range");
	a_mode_cal24: assert property (ce_i && active_o && mode_wr_i &&
		mode_calendar_24h_i && !mode_calendar_12h_ampm_i
		|=> mode_o == LPRTC_MODE_CAL24)
		else $error("24h mode not taken");
	a_off_quiet: assert property (!active_o |-> !calendar_ok_o && !irq_o)
		else $error("disabled block still active");
	a_rd_answer: assert property (ce_i && active_o && mem_req_i.rd &&
		!mem_req_i.wr |=> mem_rvalid_o)
		else $error("read not answered");
	a_ret_arm: assert property (ce_i && active_o && enable_i &&
		ret_enable_i && !ret_release_i |=> ret_status_o)
		else $error("retention not armed");
	a_ret_free: assert property (ce_i && ret_release_i |=> !ret_status_o)
		else $error("retention not released");
	a_hib_drop: assert property (hibernate_i && !ret_status_o
		|-> gpio_pad_oe_o == 8'h00 && gpio_ctrl_rst_o)
		else $error("pads driven in hibernation");
	a_reset_wake: assert property ($rose(irq_raw_o[5]) |-> irq_raw_o[6])
		else $error("reset wake without gpio wake");
	a_en_clear: assert property (ce_i && active_o && |irq_en_clr_i &&
		!(|irq_en_set_i) |=> (irq_en_o & $past(irq_en_clr_i)) == 7'h00
		&& (irq_en_o | $past(irq_en_clr_i))
		== ($past(irq_en_o) | $past(irq_en_clr_i)))
		else $error("mask disable wrong");
	a_mask_view: assert property (irq_masked_o == (irq_raw_o & irq_en_o))
		else $error("masked status wrong");
	a_irq_gate: assert property (irq_o == (active_o && |irq_masked_o))
		else $error("interrupt output wrong");
	a_slow_done: assert property (s_slow_go |=> s_slow_run)
		else $error("write complete late");
endmodule
bind lprtc_ctrl lprtc_ctrl_chk u_chk (.*);
`default_nettype wire
